// [core/tpc_trap_ctrl.v]
/*
 * tpc_trap_ctrl: exception entry and return control of the cpu.
 * holds the status word, exception and debug save registers, the
 * cause register and the in-service levels; redirects fetch.
 * assumes: decode pulses each instruction event for one clk cycle,
 * all inputs are synchronous to clk, pc/status writeback elsewhere.
 */
`timescale 1ns/10ps
`include "tpc_map.vh"

module tpc_trap_ctrl #(
  parameter LEVELS             = 8,
  parameter [31:0] IRQ_VEC     = 32'h0000_0080,
  parameter [31:0] NMI_VEC     = 32'h0000_0010
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire [31:0]   cur_pc,
  input  wire          instr_exec,
  input  wire [31:0]   instr_word,
  input  wire          trap_instr,
  input  wire [4:0]    trap_vector,
  input  wire          debug_break_instr,
  input  wire          return_from_exc_instr,
  input  wire          debug_return_instr,
  input  wire          irq_block_instr,
  input  wire          irq_unblock_instr,
  input  wire          sysreg_load_instr,
  input  wire [4:0]    sysreg_sel,
  input  wire [31:0]   sysreg_wdata,
  input  wire          nmi_req,
  input  wire [LEVELS-1:0] irq_pending,
  output reg           redirect,
  output reg  [31:0]   redirect_pc,
  output reg           flush,
  output reg           irq_ack,
  output reg  [2:0]    irq_ack_level,
  output wire [31:0]   status_word,
  output reg  [LEVELS-1:0] in_service_levels,
  output reg  [31:0]   sysreg_rdata
);

  ////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]   program_status_word;
  reg  [31:0]  exc_saved_pc;
  reg  [31:0]  exc_saved_status;
  reg  [15:0]  exc_cause_code;
  reg  [31:0]  dbg_saved_pc;
  reg  [31:0]  dbg_saved_status;
  reg          dbg_window;

  // reset image of the status word; only the low byte is stored
  localparam [31:0] SW_RESET = `TPC_SW_RESET;

  // upper bits of the status word are hard zero
  assign status_word = {24'h00_0000, program_status_word};

  wire trap_active_flag    = program_status_word[`TPC_SW_EP];
  wire nonmask_active_flag = program_status_word[`TPC_SW_NP];
  wire irq_block_flag      = program_status_word[`TPC_SW_ID];
  // returns out of nmi or exception service keep the levels
  wire isl_release = !trap_active_flag && !nonmask_active_flag;

  ////////////////////////////////////////////////////////////////////
  // illegal opcode decode
  wire bad_opcode_trap = instr_exec
    && (instr_word[10:5] == `TPC_ILG_OP)
    && (instr_word[26:23] >= `TPC_ILG_SUB_MIN)
    && !instr_word[16];

  wire dbg_entry = bad_opcode_trap || debug_break_instr;

  ////////////////////////////////////////////////////////////////////
  // priority: level 0 is highest; one loop finds both the best
  // pending level and the level now in service
  reg  [2:0]  pend_lvl;
  reg         pend_any;
  reg  [2:0]  serv_lvl;
  reg         serv_any;
  integer     i;

  always @* begin
    pend_lvl = 3'd0;
    pend_any = 1'b0;
    serv_lvl = 3'd0;
    serv_any = 1'b0;
    for (i = LEVELS - 1; i >= 0; i = i - 1) begin
      if (irq_pending[i]) begin
        pend_lvl = i[2:0];
        pend_any = 1'b1;
      end
      if (in_service_levels[i]) begin
        serv_lvl = i[2:0];
        serv_any = 1'b1;
      end
    end
  end

  // only a strictly higher level may nest; equal or lower waits
  wire irq_take = pend_any && !irq_block_flag
    && (!serv_any || (pend_lvl < serv_lvl));

  // vectors 00-0f share one entry, 10-1f the other
  wire [31:0] trap_target = trap_vector[4] ? `TPC_TRAP_HI_VEC
                                           : `TPC_TRAP_LO_VEC;
  // each maskable level owns a 16-byte slot above the base
  wire [31:0] irq_target  = IRQ_VEC + {25'd0, pend_lvl, 4'h0};

  ////////////////////////////////////////////////////////////////////
  // one event per cycle except a load other than to the status word, which may pair with irq block/unblock; debug entry first, load and block/unblock last
  // a pulse that loses arbitration is gone; level requests such as
  // nmi and pending lines simply win on a later cycle
  wire do_dbg   = dbg_entry;
  wire do_trap  = !do_dbg && trap_instr;
  wire do_debug_return_instr = !do_dbg && !do_trap && debug_return_instr;
  wire do_return_from_exc_instr  = !do_dbg && !do_trap && !do_debug_return_instr
                  && return_from_exc_instr;
  wire busy     = do_dbg || do_trap || do_debug_return_instr || do_return_from_exc_instr;
  wire do_nmi   = !busy && nmi_req;
  wire do_irq   = !busy && !do_nmi && irq_take;
  wire do_load  = !busy && !do_nmi && !do_irq && sysreg_load_instr;

  // debug saves only reachable inside the debug window
  wire dbg_ok   = dbg_window;

  ////////////////////////////////////////////////////////////////////
  // next values
  reg  [7:0]   next_psw;
  reg  [31:0]  next_pc;
  reg          next_redirect;
  reg  [LEVELS-1:0] next_isl;
  reg  [LEVELS-1:0] hi_bit;

  always @* begin
    next_psw      = program_status_word;
    next_pc       = redirect_pc;
    next_redirect = 1'b0;
    next_isl      = in_service_levels;
    // one-hot of the top level in service, dropped by a plain return
    hi_bit        = {LEVELS{1'b0}};
    hi_bit[serv_lvl] = serv_any;
    if (do_dbg) begin
      next_psw[`TPC_SW_NP] = 1'b1;
      next_psw[`TPC_SW_EP] = 1'b1;
      next_psw[`TPC_SW_ID] = 1'b1;
      next_pc       = `TPC_DBG_VEC;
      next_redirect = 1'b1;
    end else if (do_trap) begin
      next_psw[`TPC_SW_EP] = 1'b1;
      next_psw[`TPC_SW_ID] = 1'b1;
      next_pc       = trap_target;
      next_redirect = 1'b1;
    end else if (do_debug_return_instr) begin
      next_psw      = dbg_saved_status[7:0];
      next_pc       = dbg_saved_pc;
      next_redirect = 1'b1;
    end else if (do_return_from_exc_instr) begin
      // handler must leave ep=0, np=0 before this return for its level to drop
      next_psw      = exc_saved_status[7:0];
      next_pc       = exc_saved_pc;
      next_redirect = 1'b1;
      if (isl_release)
        next_isl = in_service_levels & ~hi_bit;
    end else if (do_nmi) begin
      next_psw[`TPC_SW_NP] = 1'b1;
      next_psw[`TPC_SW_ID] = 1'b1;
      next_pc       = NMI_VEC;
      next_redirect = 1'b1;
    end else if (do_irq) begin
      next_psw[`TPC_SW_ID] = 1'b1;
      next_pc       = irq_target;
      next_redirect = 1'b1;
      next_isl[pend_lvl] = 1'b1;
    end else if (do_load && sysreg_sel == `TPC_SR_PSW) begin
      next_psw = sysreg_wdata[7:0];
    end else if (irq_block_instr) begin
      next_psw[`TPC_SW_ID] = 1'b1;
    end else if (irq_unblock_instr) begin
      next_psw[`TPC_SW_ID] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status word, redirect and in-service levels
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_status_word               <= SW_RESET[7:0];
      redirect          <= 1'b0;
      flush             <= 1'b0;
      redirect_pc       <= 32'h0000_0000;
      in_service_levels <= {LEVELS{1'b0}};
      irq_ack           <= 1'b0;
      irq_ack_level     <= 3'd0;
    end else begin
      program_status_word               <= next_psw;
      redirect          <= next_redirect;
      // younger fetched instructions must not retire
      flush             <= next_redirect;
      redirect_pc       <= next_pc;
      in_service_levels <= next_isl;
      irq_ack           <= do_irq;
      if (do_irq)
        irq_ack_level   <= pend_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // exception save registers and cause
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_saved_pc     <= 32'h0000_0000;
      exc_saved_status <= 32'h0000_0000;
      exc_cause_code   <= 16'h0000;
    end else if (do_trap) begin
      exc_saved_pc     <= cur_pc;
      exc_saved_status <= status_word;
      exc_cause_code   <= `TPC_CODE_TRAP
                          | {11'd0, trap_vector};
    end else if (do_nmi || do_irq) begin
      // nested entry overwrites: software keeps its own copy
      exc_saved_pc     <= cur_pc;
      exc_saved_status <= status_word;
      exc_cause_code   <= do_nmi ? `TPC_CODE_NMI
                          : (`TPC_CODE_IRQ | {9'd0, pend_lvl, 4'h0});
    end else if (do_load) begin
      if (sysreg_sel == `TPC_SR_EPC)
        exc_saved_pc     <= sysreg_wdata;
      if (sysreg_sel == `TPC_SR_EPSW)
        exc_saved_status <= {24'h00_0000, sysreg_wdata[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // debug save registers and their access window
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_saved_pc     <= 32'h0000_0000;
      dbg_saved_status <= 32'h0000_0000;
      dbg_window       <= 1'b0;
    end else if (do_dbg) begin
      dbg_saved_pc     <= cur_pc;
      dbg_saved_status <= status_word;
      dbg_window       <= 1'b1;
    end else if (do_debug_return_instr) begin
      dbg_window       <= 1'b0;
    end else if (do_load && dbg_ok) begin
      if (sysreg_sel == `TPC_SR_DPC)
        dbg_saved_pc     <= sysreg_wdata;
      if (sysreg_sel == `TPC_SR_DPSW)
        dbg_saved_status <= {24'h00_0000, sysreg_wdata[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // system register read, one cycle behind the select
  reg [31:0] next_rdata;

  always @* begin
    case (sysreg_sel)
      `TPC_SR_EPC:  next_rdata = exc_saved_pc;
      `TPC_SR_EPSW: next_rdata = exc_saved_status;
      `TPC_SR_ECR:  next_rdata = {16'h0000, exc_cause_code};
      `TPC_SR_PSW:  next_rdata = status_word;
      // outside the window the debug saves read as zero
      `TPC_SR_DPC:  next_rdata = dbg_ok ? dbg_saved_pc
                                        : 32'h0000_0000;
      `TPC_SR_DPSW: next_rdata = dbg_ok ? dbg_saved_status
                                        : 32'h0000_0000;
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sysreg_rdata <= 32'h0000_0000;
    else
      sysreg_rdata <= next_rdata;
  end

endmodule

// [common/tpc_map.vh]
/*
 * tpc_map.vh: constants of the trap and return control block:
 * status word fields, handler addresses, system register indices,
 * cause codes and reset values.
 * assumes: included by core/tpc_trap_ctrl.v only, by bare name.
 */
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// status word fields
`define TPC_SW_NP         7
`define TPC_SW_EP         6
`define TPC_SW_ID         5
`define TPC_SW_RESET      32'h0000_0020

// handler addresses
`define TPC_TRAP_LO_VEC   32'h0000_0040
`define TPC_TRAP_HI_VEC   32'h0000_0050
`define TPC_DBG_VEC       32'h0000_0060

// illegal opcode pattern
`define TPC_ILG_OP        6'h3f
`define TPC_ILG_SUB_MIN   4'h7

// system register indices (for load and read; ECR is read only)
`define TPC_SR_EPC        5'h00
`define TPC_SR_EPSW       5'h01
`define TPC_SR_ECR        5'h04
`define TPC_SR_PSW        5'h05
`define TPC_SR_DPC        5'h10
`define TPC_SR_DPSW       5'h11

// cause codes
`define TPC_CODE_TRAP     16'h0040
`define TPC_CODE_NMI      16'h0010
`define TPC_CODE_IRQ      16'h1000

`endif

// [verif/tpc_trap_ctrl_props.sv]
/* tpc_trap_ctrl_props: port checker of the trap control block.
   assumes: bound to tpc_trap_ctrl, one clock domain. */
`timescale 1ns/10ps
module tpc_trap_ctrl_props #(
  parameter        LEVELS  = 8,
  parameter [31:0] NMI_VEC = 32'h0000_0010
) (
  input wire              clk,
  input wire              rst_n,
  input wire              instr_exec,
  input wire [31:0]       instr_word,
  input wire              trap_instr,
  input wire [4:0]        trap_vector,
  input wire              debug_break_instr,
  input wire              return_from_exc_instr,
  input wire              debug_return_instr,
  input wire              nmi_req,
  input wire              redirect,
  input wire [31:0]       redirect_pc,
  input wire              flush,
  input wire              irq_ack,
  input wire [2:0]        irq_ack_level,
  input wire [31:0]       status_word,
  input wire [LEVELS-1:0] in_service_levels
);
  wire ilg = instr_exec && instr_word[10:5] == 6'h3f &&
             instr_word[26:23] >= 4'h7 && !instr_word[16];
  wire dbg = ilg || debug_break_instr;
  wire trp = trap_instr && !dbg;
  wire hi  = dbg || trap_instr || debug_return_instr || return_from_exc_instr;
  // levels at or above the acked one must have been idle
  wire [LEVELS-1:0] upto = ~(({LEVELS{1'b1}} << 1) << irq_ack_level);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
////////////////////////////////////////
  reset_value_a: assert property (
    $rose(rst_n) |-> status_word == 32'h0000_0020)
    else $error("status word reset value wrong");
  upper_zero_a: assert property (
    status_word[31:8] == 24'h00_0000) else $error("status upper bits set");
  trap_target_a: assert property (
    trp |=> redirect && redirect_pc ==
      ($past(trap_vector[4]) ? 32'h0000_0050 : 32'h0000_0040))
    else $error("trap handler address wrong");
  trap_flags_a: assert property (
    trp |=> status_word[6:5] == 2'b11) else $error("trap flags not set");
  dbg_entry_a: assert property (
    dbg |=> redirect && redirect_pc == 32'h0000_0060 &&
      status_word[7:5] == 3'b111) else $error("debug entry wrong");
  flush_match_a: assert property (
    flush == redirect) else $error("flush differs from redirect");
  block_gate_a: assert property (
    irq_ack |-> !$past(status_word[5])) else $error("ack while blocked");
  no_lower_a: assert property (
    irq_ack |-> ($past(in_service_levels) & upto) == 0)
    else $error("ack without higher priority");
  nmi_take_a: assert property (
    nmi_req && !hi |=> redirect && redirect_pc == NMI_VEC)
    else $error("nonmaskable request not taken");
  cover property (trp);
  cover property (dbg);
  cover property (irq_ack && irq_ack_level == 3'd1);
endmodule
bind tpc_trap_ctrl tpc_trap_ctrl_props #(.LEVELS(LEVELS), .NMI_VEC(NMI_VEC))
  i_props (.clk(clk), .rst_n(rst_n), .instr_exec(instr_exec),
    .instr_word(instr_word), .trap_instr(trap_instr),
    .trap_vector(trap_vector), .debug_break_instr(debug_break_instr),
    .return_from_exc_instr(return_from_exc_instr),
    .debug_return_instr(debug_return_instr), .nmi_req(nmi_req),
    .redirect(redirect), .redirect_pc(redirect_pc), .flush(flush),
    .irq_ack(irq_ack), .irq_ack_level(irq_ack_level),
    .status_word(status_word), .in_service_levels(in_service_levels));

// [verif/tpc_fetch_model.sv]
/* tpc_fetch_model: fetch pc of the decode side.
   assumes: redirect is a one-cycle pulse from the trap block. */
`timescale 1ns/10ps
module tpc_fetch_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        redirect,
  input  wire [31:0] redirect_pc,
  output reg  [31:0] fetch_pc
);
  // restart at the target so nothing fetched after the trap is kept
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) fetch_pc <= 32'h0000_0000;
    else if (redirect) fetch_pc <= redirect_pc;
    else fetch_pc <= fetch_pc + 32'h0000_0004;
  end
endmodule

// [verif/tb.sv]
/* tb: self-checking bench of the trap and return control block.
   assumes: tpc_fetch_model supplies the pc of each event. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  reg         clk = 0, rst_n = 0;
  reg         ex, trp, brk, ret, dret, blk, unblk, nmi, ld;
  reg  [31:0] word, p, m, wd, s = 32'h3662_1e48;
  reg  [4:0]  vec, sel;
  reg  [7:0]  pend;
  wire        rdr, fl, ack;
  wire [31:0] rpc, sw, rd, pc;
  wire [2:0]  lvl;
  wire [7:0]  isl;
  integer     num_errors = 0, tests_run = 0, i;
  reg  [31:0] q[$];
  always #5 clk = ~clk;
  tpc_fetch_model i_tpc_fetch_model (.clk(clk), .rst_n(rst_n),
    .redirect(rdr), .redirect_pc(rpc), .fetch_pc(pc));
  tpc_trap_ctrl i_tpc_trap_ctrl (.clk(clk), .rst_n(rst_n), .cur_pc(pc),
    .instr_exec(ex), .instr_word(word), .trap_instr(trp),
    .trap_vector(vec), .debug_break_instr(brk),
    .return_from_exc_instr(ret), .debug_return_instr(dret),
    .irq_block_instr(blk), .irq_unblock_instr(unblk),
    .sysreg_load_instr(ld), .sysreg_sel(sel), .sysreg_wdata(wd),
    .nmi_req(nmi), .irq_pending(pend), .redirect(rdr), .redirect_pc(rpc),
    .flush(fl), .irq_ack(ack), .irq_ack_level(lvl), .status_word(sw),
    .in_service_levels(isl), .sysreg_rdata(rd));
////////////////////////////////////////
  function [31:0] rnd(input [31:0] x);
    rnd = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task fire;
    begin
      @(posedge clk);
      #1;
      {ex, trp, brk, ret, dret, blk, unblk, nmi, ld} = 9'h000;
    end
  endtask
  task rdsr(input [4:0] r);
    begin
      sel = r;
      @(posedge clk);
      #1;
    end
  endtask
  task close_out;
    begin
      `CHK("notes_left", 32'd0, q.size())
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // an unexpected redirect meets an unknown note and fails
  always @(posedge clk) begin
    if (rdr === 1'b1) begin
      m = (q.size() > 0) ? q.pop_front() : 32'hxxxx_xxxx;
      `CHK("redirect_pc", m, rpc)
      `CHK("flush", 1'b1, fl)
    end
  end
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
////////////////////////////////////////
  initial begin
    {ex, trp, brk, ret, dret, blk, unblk, nmi, ld} = 9'h000;
    word = 0; vec = 0; sel = 0; pend = 0; wd = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    `CHK("sw", 32'h0000_0020, sw)
    for (i = 0; i < 5; i = i + 1) begin
      s = rnd(s);
      vec = (i < 4) ? {i[1], {4{i[0]}}} : s[4:0];
      trp = 1; p = pc;
      q.push_back(vec[4] ? 32'h0000_0050 : 32'h0000_0040);
      fire;
      `CHK("flags", 2'b11, sw[6:5])
      rdsr(5'h04); `CHK("ecr", 16'h0040 | vec, rd[15:0])
      rdsr(5'h00); `CHK("epc", p, rd)
      rdsr(5'h01); `CHK("epsw", 32'h0000_0020, rd)
      ret = 1; q.push_back(p); fire;
      `CHK("sw_ret", 32'h0000_0020, sw)
      $display("trap vector %h done", vec);
    end
    for (i = 0; i < 12; i = i + 1) begin
      s = rnd(s);
      word = s; word[10:5] = 6'h3f; word[26:23] = i + 5; word[16] = (i == 10);
      ex = (i < 11); brk = (i == 11); p = pc;
      if (i >= 2 && i != 10) q.push_back(32'h0000_0060);
      fire;
      if (i >= 2 && i != 10) begin
        `CHK("dbg_sw", 3'b111, sw[7:5])
        rdsr(5'h10); `CHK("dpc", p, rd)
        rdsr(5'h11); `CHK("dpsw", 32'h0000_0020, rd)
        dret = 1; q.push_back(p); fire;
        `CHK("dret_sw", 32'h0000_0020, sw)
        rdsr(5'h10); `CHK("dpc_shut", 32'h0, rd)
      end else `CHK("no_trap", 32'h0000_0020, sw)
      $display("debug entry case %0d done", i);
    end
    pend = 8'h08; repeat (4) @(posedge clk); #1;
    `CHK("blocked", 8'h00, isl)
    unblk = 1; q.push_back(32'h0000_00b0); fire;
    @(posedge clk); #1 pend = 8'h00;
    `CHK("ack", 1'b1, ack)
    `CHK("lvl", 3'd3, lvl)
    unblk = 1; fire;
    pend = 8'h28; repeat (4) @(posedge clk); #1;
    `CHK("held", 8'h08, isl)
    pend = 8'h2a; p = pc; q.push_back(32'h0000_0090);
    @(posedge clk); #1 pend = 8'h00;
    `CHK("nest", 8'h0a, isl)
    ret = 1; q.push_back(p); fire;
    `CHK("return_from_exc_instr_isl", 8'h08, isl)
    blk = 1; fire;
    nmi = 1; p = pc; q.push_back(32'h0000_0010); fire;
    `CHK("nmi_np", 1'b1, sw[7])
    ret = 1; q.push_back(p); fire;
    `CHK("nmi_isl", 8'h08, isl)
    ret = 1; q.push_back(p); fire;
    `CHK("last_isl", 8'h00, isl)
    $display("nesting test done");
    // handler overwrites the saved pc, restores it from its own copy, then loads the status word
    trp = 1; vec = 5'h03; p = pc; q.push_back(32'h0000_0040); fire;
    s = rnd(s); ld = 1; sel = 5'h00; wd = s; fire;
    rdsr(5'h00); `CHK("epc_load", s, rd)
    ld = 1; wd = p; fire;
    ld = 1; sel = 5'h05; wd = 32'h0000_00a0; fire;
    `CHK("psw_load", 32'h0000_00a0, sw)
    ld = 1; wd = 32'h0000_0060; fire;
    ret = 1; q.push_back(p); fire;
    `CHK("ld_ret", 32'h0000_0020, sw)
    $display("load test done");
    @(posedge clk); #1 rst_n = 0;
    #1 `CHK("rst_sw", 32'h0000_0020, sw)
    `CHK("rst_isl", 8'h00, isl)
    @(posedge clk); #1 rst_n = 1;
    $display("reset test done");
    @(posedge clk);
    close_out;
  end
endmodule
